// file: common/tdrc_pkg.sv
// ============================================================
// shared constants and types of the text display refresh controller
package tdrc_pkg;

  // ==========================================================
  // clocking
  localparam int unsigned SYS_CLK_HZ      = 25_771_500;  // dot-rate system clock
  localparam int unsigned CPU_DIV         = 14;          // host clock divider
  localparam int unsigned CPU_CLK_HZ      = SYS_CLK_HZ / CPU_DIV;

  // ==========================================================
  // character cell and raster geometry
  localparam int unsigned DOTS_PER_CELL   = 9;
  localparam int unsigned LINES_PER_ROW   = 15;
  localparam int unsigned VIS_SLOTS       = 80;
  localparam int unsigned RETRACE_SLOTS   = 35;
  localparam int unsigned SLOTS_PER_LINE  = VIS_SLOTS + RETRACE_SLOTS;
  localparam int unsigned ROWS_PER_FRAME  = 26;
  localparam int unsigned LINES_60HZ      = 415;
  localparam int unsigned LINES_50HZ      = 498;
  localparam int unsigned PTR_ROWS        = 24;          // rows refreshed from linked pointers
  localparam int unsigned BLANK_ROW       = 24;          // separator row, always blanked
  localparam int unsigned LABEL_ROW       = 25;          // soft-label row

  localparam logic [3:0]  LAST_DOT        = 4'(DOTS_PER_CELL - 1);
  localparam logic [6:0]  LAST_SLOT       = 7'(SLOTS_PER_LINE - 1);
  localparam logic [3:0]  LAST_LINE       = 4'(LINES_PER_ROW - 1);
  localparam logic [4:0]  RETRACE_ROW     = 5'(ROWS_PER_FRAME);
  localparam logic [8:0]  TOTAL_60        = 9'(LINES_60HZ - 1);
  localparam logic [8:0]  TOTAL_50        = 9'(LINES_50HZ - 1);

  // ==========================================================
  // fetch and display pipeline, in character slots
  localparam logic [6:0]  FETCH_FIRST     = 7'h01;       // slot 0 reads the row pointer
  localparam logic [6:0]  FETCH_LAST      = 7'(VIS_SLOTS);
  localparam logic [6:0]  VIS_FIRST       = 7'h03;       // fetch slot plus two slots of pipeline
  localparam logic [6:0]  VIS_LAST        = 7'(VIS_SLOTS + 2);

  // ==========================================================
  // drive pulses
  localparam logic [6:0]  HDRV_FIRST      = 7'h58;
  localparam logic [6:0]  HDRV_LAST       = 7'h61;
  localparam logic [8:0]  VDRV_FIRST      = 9'(ROWS_PER_FRAME * LINES_PER_ROW + 4);
  localparam logic [8:0]  VDRV_LAST       = 9'(ROWS_PER_FRAME * LINES_PER_ROW + 6);

  // ==========================================================
  // display memory map, offsets inside the display window
  localparam logic [11:0] TOS_ADDR        = 12'h080;
  localparam logic [11:0] SKL_ADDR        = 12'h081;
  localparam int unsigned LINK_SHIFT      = 4;           // a link is 16 bytes

  // ==========================================================
  // memory cycle shift register
  localparam int unsigned MEM_STAGES      = 8;
  localparam int unsigned COL_STAGE       = 2;
  localparam int unsigned CAS_STAGE       = 3;

  // ==========================================================
  // owner of the current display memory cycle
  typedef enum logic [5:0] {
    TDRC_IDLE   = 6'b000001,
    TDRC_TOS    = 6'b000010,
    TDRC_SKL    = 6'b000100,
    TDRC_ROWPTR = 6'b001000,
    TDRC_CHAR   = 6'b010000,
    TDRC_HOST   = 6'b100000
  } tdrc_owner_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } tdrc_host_req_t;

  typedef struct packed {
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [5:0]  addr;
    logic [7:0]  wdata;
  } tdrc_mem_pins_t;

endpackage

// file: core/tdrc_mem_seq.sv
`timescale 1ns/1ns
// ============================================================
// display memory cycle delay line
module tdrc_mem_seq #(
  parameter int unsigned STAGES    = tdrc_pkg::MEM_STAGES,
  parameter int unsigned COL_STAGE = tdrc_pkg::COL_STAGE,
  parameter int unsigned CAS_STAGE = tdrc_pkg::CAS_STAGE
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // cycle request
  input  wire logic start_i,
  // strobe timing
  output logic      ras_n_o,
  output logic      cas_n_o,
  output logic      col_sel_o,
  output logic      done_o
);

  logic [STAGES-1:0] stage_q;

  // request ripples through the delay line
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[STAGES-2:0], start_i};
    end
  end

  // strobes decoded from taps of the delay line
  assign ras_n_o   = ~(|stage_q[STAGES-2:0]);
  assign col_sel_o = |stage_q[STAGES-1:COL_STAGE];
  assign cas_n_o   = ~(|stage_q[STAGES-2:CAS_STAGE]);
  assign done_o    = stage_q[STAGES-1];  // data valid, last tap

endmodule

// file: core/tdrc_refresh.sv
`timescale 1ns/1ns
module tdrc_refresh (
  // clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  // configuration and control
  input  wire logic                    rate_50hz_i,
  input  wire logic                    host_blank_i,
  // host display memory port
  input  wire tdrc_pkg::tdrc_host_req_t host_i,
  output logic                         host_wait_o,
  output logic                         host_ack_o,
  output logic [7:0]                   host_rdata_o,
  output logic                         cpu_clk_o,
  // display memory pins
  output tdrc_pkg::tdrc_mem_pins_t     mem_o,
  input  wire logic [7:0]              mem_rdata_i,
  // glyph rom
  output logic [10:0]                  glyph_addr_o,
  input  wire logic [7:0]              glyph_data_i,
  // video and sweep
  output logic [1:0]                   video_o,
  output logic                         blank_o,
  output logic                         hdrive_o,
  output logic                         vdrive_o
);

  // ==========================================================
  // declarations
  logic [3:0]            dot_q;
  logic [6:0]            pos_q;
  logic [3:0]            line_q;
  logic [4:0]            row_q;
  logic [8:0]            vline_q;
  logic [3:0]            div_q;
  logic                  cpu_clk_q;
  logic [2:0]            rate_sync_q;
  logic                  rate_50_q;
  tdrc_pkg::tdrc_owner_t owner_q;
  tdrc_pkg::tdrc_owner_t owner_d;
  logic [11:0]           cyc_addr_q;
  logic [11:0]           cyc_addr_d;
  logic                  cyc_start;
  logic                  host_we_q;
  logic [7:0]            host_wdata_q;
  logic                  host_served_q;
  logic                  host_ack_q;
  logic [7:0]            host_rdata_q;
  logic [5:0]            row_idx_q;
  logic [5:0]            skl_idx_q;
  logic [11:0]           char_ptr_q;
  logic [7:0]            char_code_q;
  logic [10:0]           glyph_addr_q;
  logic [6:0]            pix_q;
  logic                  half_q, vis_q, prev_dot_q, blank_q, hdrive_q, vdrive_q;
  logic [1:0]            video_q;
  logic                  slot_end, line_end, last_line, frame_last, disp_row;
  logic [8:0]            frame_total;
  logic                  refresh_row_decode, char_slot_hold;
  logic                  seq_ras_n, seq_cas_n, seq_col_sel, seq_done;
  logic                  dot_bit, blank_now, next_vis;

  // ==========================================================
  // raster timing
  // slot and line boundaries off the dot counter
  assign slot_end    = (dot_q == tdrc_pkg::LAST_DOT);
  assign line_end    = slot_end && (pos_q == tdrc_pkg::LAST_SLOT);
  assign last_line   = (line_q == tdrc_pkg::LAST_LINE);
  assign frame_total = rate_50_q ? tdrc_pkg::TOTAL_50 : tdrc_pkg::TOTAL_60;
  assign frame_last  = (vline_q == frame_total);
  assign disp_row    = (row_q < tdrc_pkg::RETRACE_ROW) && (row_q != 5'(tdrc_pkg::BLANK_ROW));

  // dot position counter, nine dots per cell
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dot_q <= 4'h0;
    end else if (slot_end) begin
      dot_q <= 4'h0;
    end else begin
      dot_q <= dot_q + 4'h1;
    end
  end

  // character position counter, 115 slots per line
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_q <= 7'h00;
    end else if (line_end) begin
      pos_q <= 7'h00;
    end else if (slot_end) begin
      pos_q <= pos_q + 7'h01;
    end
  end

  // height, row and frame line counters
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_q  <= 4'h0;
      row_q   <= 5'h00;
      vline_q <= 9'h000;
    end else if (line_end) begin
      if (frame_last) begin
        vline_q <= 9'h000;
        line_q  <= 4'h0;
        row_q   <= 5'h00;
      end else begin
        vline_q <= vline_q + 9'h001;
        if (row_q != tdrc_pkg::RETRACE_ROW) begin
          if (last_line) begin
            line_q <= 4'h0;
            row_q  <= row_q + 5'h01;
          end else begin
            line_q <= line_q + 4'h1;
          end
        end
      end
    end
  end

  // host clock, system clock over fourteen
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q     <= 4'h0;
      cpu_clk_q <= 1'b0;
    end else begin
      div_q     <= (div_q == 4'(tdrc_pkg::CPU_DIV - 1)) ? 4'h0 : div_q + 4'h1;
      cpu_clk_q <= (div_q < 4'(tdrc_pkg::CPU_DIV / 2));
    end
  end

  // frame rate strap, three flops, change taken when two agree
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_sync_q <= 3'h0;
      rate_50_q   <= 1'b0;
    end else begin
      rate_sync_q <= {rate_sync_q[1:0], rate_50hz_i};
      if (rate_sync_q[1] == rate_sync_q[2]) begin
        rate_50_q <= rate_sync_q[2];
      end
    end
  end

  // horizontal and vertical drive pulses
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hdrive_q <= 1'b0;
      vdrive_q <= 1'b0;
    end else begin
      hdrive_q <= (pos_q >= tdrc_pkg::HDRV_FIRST) && (pos_q <= tdrc_pkg::HDRV_LAST);
      vdrive_q <= (vline_q >= tdrc_pkg::VDRV_FIRST) && (vline_q <= tdrc_pkg::VDRV_LAST);
    end
  end

  // ==========================================================
  // display memory arbitration
  // refresh owns slot 0 and fetch slots of displayed rows
  always_comb begin
    refresh_row_decode = 1'b0;
    owner_d            = tdrc_pkg::TDRC_IDLE;
    cyc_addr_d         = host_i.addr;
    if (frame_last && (pos_q == 7'h00)) begin
      refresh_row_decode = 1'b1;
      owner_d            = tdrc_pkg::TDRC_TOS;
      cyc_addr_d         = tdrc_pkg::TOS_ADDR;
    end else if (frame_last && (pos_q == 7'h01)) begin
      refresh_row_decode = 1'b1;
      owner_d            = tdrc_pkg::TDRC_SKL;
      cyc_addr_d         = tdrc_pkg::SKL_ADDR;
    end else if (disp_row && (pos_q == 7'h00)) begin
      refresh_row_decode = 1'b1;
      owner_d            = tdrc_pkg::TDRC_ROWPTR;
      cyc_addr_d         = {6'h00, (row_q == 5'(tdrc_pkg::LABEL_ROW)) ? skl_idx_q : row_idx_q};
    end else if (disp_row && (pos_q >= tdrc_pkg::FETCH_FIRST) && (pos_q <= tdrc_pkg::FETCH_LAST)) begin
      refresh_row_decode = 1'b1;
      owner_d            = tdrc_pkg::TDRC_CHAR;
      cyc_addr_d         = char_ptr_q;
    end else if (host_i.req && !host_served_q) begin
      owner_d            = tdrc_pkg::TDRC_HOST;
    end
  end

  // free slot for the host, and its wait
  assign char_slot_hold = host_i.req && !host_served_q;
  assign cyc_start      = (dot_q == 4'h0) && (refresh_row_decode || (owner_d == tdrc_pkg::TDRC_HOST));

  // cycle owner and address loaded at dot 0; the owner returns to idle when the done tap fires
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      owner_q      <= tdrc_pkg::TDRC_IDLE;
      cyc_addr_q   <= 12'h000;
      host_we_q    <= 1'b0;
      host_wdata_q <= 8'h00;
    end else if (dot_q == 4'h0) begin
      owner_q    <= owner_d;
      cyc_addr_q <= cyc_addr_d;
      host_we_q  <= host_i.we && (owner_d == tdrc_pkg::TDRC_HOST);
      if (owner_d == tdrc_pkg::TDRC_HOST) begin
        host_wdata_q <= host_i.wdata;
      end
    end else if (seq_done) begin
      owner_q   <= tdrc_pkg::TDRC_IDLE;
      host_we_q <= 1'b0;
    end
  end

  // host completion: wait holds until the cycle ends
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_served_q <= 1'b0;
      host_ack_q    <= 1'b0;
      host_rdata_q  <= 8'h00;
    end else begin
      host_ack_q <= seq_done && (owner_q == tdrc_pkg::TDRC_HOST);
      if (seq_done && (owner_q == tdrc_pkg::TDRC_HOST)) begin
        host_served_q <= 1'b1;
        host_rdata_q  <= mem_rdata_i;
      end else if (!host_i.req) begin
        host_served_q <= 1'b0;
      end
    end
  end

  // strobe timing from the delay shift register
  tdrc_mem_seq #(
    .STAGES    (tdrc_pkg::MEM_STAGES),
    .COL_STAGE (tdrc_pkg::COL_STAGE),
    .CAS_STAGE (tdrc_pkg::CAS_STAGE)
  ) u_seq (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (cyc_start),
    .ras_n_o    (seq_ras_n),
    .cas_n_o    (seq_cas_n),
    .col_sel_o  (seq_col_sel),
    .done_o     (seq_done)
  );

  // row/column multiplexed address and write strobe
  assign mem_o.ras_n = seq_ras_n;
  assign mem_o.cas_n = seq_cas_n;
  assign mem_o.we_n  = ~(host_we_q && !seq_ras_n);
  assign mem_o.addr  = seq_col_sel ? cyc_addr_q[11:6] : cyc_addr_q[5:0];
  assign mem_o.wdata = host_wdata_q;

  // ==========================================================
  // pointer walk
  // window bytes, row index and character pointer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      row_idx_q   <= 6'h00;
      skl_idx_q   <= 6'h00;
      char_ptr_q  <= 12'h000;
      char_code_q <= 8'h00;
    end else begin
      if (seq_done) begin
        case (owner_q)
          tdrc_pkg::TDRC_TOS: begin
            row_idx_q <= mem_rdata_i[5:0];
          end
          tdrc_pkg::TDRC_SKL: begin
            skl_idx_q <= mem_rdata_i[5:0];
          end
          tdrc_pkg::TDRC_ROWPTR: begin
            char_ptr_q <= {mem_rdata_i, 4'h0};
          end
          tdrc_pkg::TDRC_CHAR: begin
            char_code_q <= mem_rdata_i;
            char_ptr_q  <= char_ptr_q + 12'h001;
          end
          default: begin
          end
        endcase
      end
      if (line_end && last_line && (row_q < 5'(tdrc_pkg::PTR_ROWS))) begin
        row_idx_q <= row_idx_q + 6'h01;
      end
    end
  end

  // ==========================================================
  // glyph and dot generation
  // glyph address from the fetched code and scan line
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      glyph_addr_q <= 11'h000;
    end else if (dot_q == 4'h0) begin
      glyph_addr_q <= {char_code_q[6:0], line_q};
    end
  end

  // next slot lies inside the visible window
  assign next_vis = ((pos_q + 7'h01) >= tdrc_pkg::VIS_FIRST) && ((pos_q + 7'h01) <= tdrc_pkg::VIS_LAST);

  // dot shifter loaded at each slot end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pix_q  <= 7'h00;
      half_q <= 1'b0;
      vis_q  <= 1'b0;
    end else if (slot_end) begin
      pix_q  <= glyph_data_i[6:0];
      half_q <= glyph_data_i[7];
      vis_q  <= next_vis && !line_end;
    end else if (dot_q != 4'h0) begin
      pix_q <= {pix_q[5:0], 1'b0};
    end
  end

  // side dots stay dark, spacing lines stay dark
  assign dot_bit   = (dot_q != 4'h0) && (dot_q != tdrc_pkg::LAST_DOT) && pix_q[6];
  assign blank_now = !vis_q || host_blank_i || !disp_row
                  || (line_q == 4'h0) || last_line;

  // serial video, two half-dot phases per dot
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_dot_q <= 1'b0;
      video_q    <= 2'h0;
      blank_q    <= 1'b1;
    end else begin
      blank_q <= blank_now;
      if (blank_now) begin
        prev_dot_q <= 1'b0;
        video_q    <= 2'h0;
      end else begin
        prev_dot_q <= dot_bit;
        video_q    <= half_q ? {prev_dot_q, dot_bit} : {dot_bit, dot_bit};
      end
    end
  end

  // ==========================================================
  // outputs
  assign host_wait_o  = char_slot_hold;
  assign host_ack_o   = host_ack_q;
  assign host_rdata_o = host_rdata_q;
  assign cpu_clk_o    = cpu_clk_q;
  assign glyph_addr_o = glyph_addr_q;
  assign video_o      = video_q;
  assign blank_o      = blank_q;
  assign hdrive_o     = hdrive_q;
  assign vdrive_o     = vdrive_q;

endmodule

// file: tb/tdrc_mem_model.sv
`timescale 1ns/1ns
// ============================================================
// display memory and glyph rom on the far side
module tdrc_mem_model (
  // clock
  input  wire logic                     core_clk_i,
  // memory pins and glyph address
  input  wire tdrc_pkg::tdrc_mem_pins_t mem_i,
  input  wire logic [10:0]              glyph_addr_i,
  // read data
  output logic [7:0]                    mem_rdata_o,
  output logic [7:0]                    glyph_data_o
);
  logic [7:0] ram [4096];
  logic [5:0] row_q = 6'h00;
  logic [7:0] dat_q = 8'h00;
  logic       ras_q = 1'b1;
  logic       cas_q = 1'b1;
  logic       rd_q  = 1'b0;

  // preset contents so refresh reads are never unknown
  initial begin
    for (int i = 0; i < 4096; i++) ram[i] = 8'(i) ^ 8'h5a;
  end

  // row half at ras fall, column half at cas fall
  always @(posedge core_clk_i) begin
    if (ras_q && !mem_i.ras_n) row_q <= mem_i.addr;
    if (cas_q && !mem_i.cas_n && !mem_i.we_n) ram[{mem_i.addr, row_q}] <= mem_i.wdata;
    if (cas_q && !mem_i.cas_n) dat_q <= ram[{mem_i.addr, row_q}];
    ras_q <= mem_i.ras_n;
    cas_q <= mem_i.cas_n;
    rd_q  <= !mem_i.cas_n;
  end

  // released bus shows the inverse of the last byte
  assign mem_rdata_o  = rd_q ? dat_q : ~dat_q;
  // seven dot bits plus half-shift bit
  assign glyph_data_o = glyph_addr_i[10:3] ^ {4'h0, glyph_addr_i[3:0]};
endmodule

// file: tb/tdrc_refresh_asserts.sv
`timescale 1ns/1ns
// ============================================================
// port checker of the refresh controller
module tdrc_refresh_asserts (
  // clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  // observed ports
  input  wire logic                     host_blank_i,
  input  wire tdrc_pkg::tdrc_host_req_t host_i,
  input  wire logic                     host_ack_o,
  input  wire logic                     cpu_clk_o,
  input  wire tdrc_pkg::tdrc_mem_pins_t mem_o,
  input  wire logic                     blank_o,
  input  wire logic                     hdrive_o
);
  logic [10:0] line_q;
  logic        seen_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // cycles since the last horizontal drive edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_q <= 11'h000;
      seen_q <= 1'b0;
    end else if ($rose(hdrive_o)) begin
      line_q <= 11'h000;
      seen_q <= 1'b1;
    end else begin
      line_q <= line_q + 11'h001;
    end
  end

  // strobe phases of one memory cycle
  sequence row_phase_s; (!mem_o.ras_n && mem_o.cas_n) [*3]; endsequence
  sequence col_phase_s; (!mem_o.ras_n && !mem_o.cas_n) [*4]; endsequence

  cpu_high_a: assert property ($rose(cpu_clk_o) |=> cpu_clk_o [*6] ##1 !cpu_clk_o)
    else $error("host clock high time wrong");
  cpu_low_a: assert property ($fell(cpu_clk_o) |=> !cpu_clk_o [*6] ##1 cpu_clk_o)
    else $error("host clock low time wrong");
  line_period_a: assert property ($rose(hdrive_o) && seen_q |-> line_q == 11'h40a)
    else $error("line length wrong");
  retrace_blank_a: assert property (hdrive_o |-> blank_o)
    else $error("video shown in retrace");
  host_blank_a: assert property (host_blank_i |=> blank_o)
    else $error("host blanking ignored");
  wait_bound_a: assert property ($rose(host_i.req) |-> ##[9:760] host_ack_o)
    else $error("host access not served");
  ack_cycle_a: assert property (host_ack_o |-> !$past(mem_o.ras_n, 8) && !$past(mem_o.cas_n, 2))
    else $error("host done without memory cycle");
  strobe_seq_a: assert property ($fell(mem_o.ras_n) |-> row_phase_s ##1 col_phase_s ##1 (mem_o.ras_n && mem_o.cas_n))
    else $error("strobe timing wrong");
  write_in_ras_a: assert property (!mem_o.we_n |-> !mem_o.ras_n)
    else $error("write strobe outside row strobe");
  cas_in_ras_a: assert property (!mem_o.cas_n |-> !mem_o.ras_n)
    else $error("column strobe outside row strobe");
endmodule

bind tdrc_refresh tdrc_refresh_asserts tdrc_refresh_asserts_i (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .host_blank_i(host_blank_i), .host_i(host_i),
  .host_ack_o(host_ack_o), .cpu_clk_o(cpu_clk_o), .mem_o(mem_o), .blank_o(blank_o), .hdrive_o(hdrive_o)
);

// file: tb/tdrc_refresh_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("Error at %0t: %h vs %h", $time, (a), (b)); end end
// ============================================================
// refresh controller bench
module tdrc_refresh_tb_top;
  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  exp;
  } tdrc_row_t;

  logic                     core_clk_i   = 1'b0;
  logic                     rst_n_i      = 1'b0;
  logic                     rate_50hz_i  = 1'b0;
  logic                     host_blank_i = 1'b0;
  tdrc_pkg::tdrc_host_req_t host_i       = '0;
  tdrc_pkg::tdrc_mem_pins_t mem_o;
  logic                     host_wait_o, host_ack_o, cpu_clk_o, blank_o, hdrive_o, vdrive_o;
  logic [7:0]               host_rdata_o, mem_rdata_i, glyph_data_i, rd;
  logic [10:0]              glyph_addr_o;
  logic [1:0]               video_o;
  logic [11:0]              cap_q [$];
  logic [5:0]               row_p;
  logic                     cap_en = 1'b0;
  logic                     ras_p  = 1'b1;
  logic                     cas_p  = 1'b1;
  int                       n_fail = 0;
  int                       check_count = 0;
  int                       cyc, cnt, vcnt;
  tdrc_row_t                rows [11] = '{
    '{1'b1, 12'h100, 8'h41, 8'h00}, '{1'b1, 12'h101, 8'h42, 8'h00}, '{1'b1, 12'h14f, 8'h7e, 8'h00},
    '{1'b1, 12'hfff, 8'ha5, 8'h00}, '{1'b1, 12'h03f, 8'hc3, 8'h00}, '{1'b0, 12'h100, 8'h00, 8'h41},
    '{1'b0, 12'h101, 8'h00, 8'h42}, '{1'b0, 12'h14f, 8'h00, 8'h7e}, '{1'b0, 12'hfff, 8'h00, 8'ha5},
    '{1'b0, 12'h03f, 8'h00, 8'hc3}, '{1'b0, 12'h200, 8'h00, 8'h5a}};

  // dot-rate clock
  initial forever #10 core_clk_i = ~core_clk_i;

  tdrc_refresh tdrc_refresh_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .rate_50hz_i(rate_50hz_i), .host_blank_i(host_blank_i),
    .host_i(host_i), .host_wait_o(host_wait_o), .host_ack_o(host_ack_o), .host_rdata_o(host_rdata_o),
    .cpu_clk_o(cpu_clk_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .glyph_addr_o(glyph_addr_o),
    .glyph_data_i(glyph_data_i), .video_o(video_o), .blank_o(blank_o), .hdrive_o(hdrive_o), .vdrive_o(vdrive_o)
  );
  tdrc_mem_model tdrc_mem_model_i (
    .core_clk_i(core_clk_i), .mem_i(mem_o), .glyph_addr_i(glyph_addr_o),
    .mem_rdata_o(mem_rdata_i), .glyph_data_o(glyph_data_i)
  );

  // memory cycle address monitor
  always @(posedge core_clk_i) begin
    if (cap_en && ras_p && !mem_o.ras_n) row_p = mem_o.addr;
    if (cap_en && cas_p && !mem_o.cas_n) cap_q.push_back({mem_o.addr, row_p});
    ras_p = mem_o.ras_n;
    cas_p = mem_o.cas_n;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wait_ok();
    if (cnt >= 2100) begin
      n_fail++;
      end_sim();
    end
  endtask

  // reset held 12 cycles, outputs checked before release
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    `CHK(blank_o, 1'b1)
    `CHK({mem_o.ras_n, mem_o.cas_n, mem_o.we_n}, 3'b111)
    `CHK({hdrive_o, host_ack_o, cpu_clk_o, host_wait_o}, 4'h0)
    rst_n_i <= 1'b1;
  endtask

  // one host byte, held until the done pulse is sampled
  task automatic host_xfer(input logic we, input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge core_clk_i);
    host_i <= '{1'b1, we, a, d};
    for (i = 0; i < 1000; i++) begin
      @(posedge core_clk_i);
      if (i == 0) `CHK(host_wait_o, 1'b1)
      if (host_ack_o === 1'b1) break;
    end
    if (i < 1000) `CHK(host_wait_o, 1'b0)
    cnt = (i == 1000) ? 2100 : 0;
    wait_ok();
    rd = host_rdata_o;
    cyc = i;
    host_i.req <= 1'b0;
    @(posedge core_clk_i);
  endtask

  initial begin
    do_reset();
    // line 0 is a spacing line, line 1 shows 80 cells
    for (int l = 0; l < 2; l++) begin
      cnt = 0;
      vcnt = 0;
      repeat (1035) begin
        @(posedge core_clk_i);
        if (blank_o === 1'b0) cnt++;
        if (video_o !== 2'h0) vcnt++;
      end
      `CHK(cnt, l * 720)
      `CHK(vcnt > 0, l == 1)
    end
    // pointer 0 names link 0x10, then one line of refresh addresses
    host_xfer(1'b1, 12'h000, 8'h10);
    for (cnt = 0; cnt < 2100 && hdrive_o !== 1'b1; cnt++) @(posedge core_clk_i);
    wait_ok();
    cap_en = 1'b1;
    repeat (1035) @(posedge core_clk_i);
    cap_en = 1'b0;
    `CHK(cap_q.size(), 81)
    for (int k = 0; k < 81; k++) begin
      `CHK(cap_q[k], (k == 0) ? 12'h000 : 12'h100 + 12'(k - 1))
    end
    // host read issued in slot 0 waits for the refresh slots
    for (cnt = 0; cnt < 2100 && mem_o.ras_n !== 1'b0; cnt++) @(posedge core_clk_i);
    wait_ok();
    host_xfer(1'b0, 12'h000, 8'h00);
    `CHK(rd, 8'h10)
    `CHK(cyc >= 720 && cyc <= 760, 1'b1)
    // table of writes and read-backs on link boundaries
    foreach (rows[r]) begin
      host_xfer(rows[r].we, rows[r].addr, rows[r].wdata);
      if (!rows[r].we) `CHK(rd, rows[r].exp)
    end
    // host blanking over a visible cell
    for (cnt = 0; cnt < 2100 && blank_o !== 1'b0; cnt++) @(posedge core_clk_i);
    wait_ok();
    host_blank_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    `CHK(blank_o, 1'b1)
    host_blank_i <= 1'b0;
    // second reset in mid-run, memory keeps its bytes
    rate_50hz_i <= 1'b1;
    do_reset();
    host_xfer(1'b0, 12'h14f, 8'h00);
    `CHK(rd, 8'h7e)
    end_sim();
  end
endmodule
